// >>> cap_core.sv
// cap_core: core end of the configuration access port, holding a word array
// assumes the requester keeps one access outstanding and drives the port clock
// assumes all port wires settle well before the port clock rises
// assumes each port-clock phase spans several mclk cycles
// unwritten words read back unknown; the store has no reset
`timescale 1ns/1ps
module cap_core
    import cap_pkg::*;
(
    // system
    input wire logic mclk,
    input wire logic sys_rst,
    // port
    cap_if.core bus
);
    // synchroniser stages for the port wires
    logic clkS1_q;
    logic clkS2_q;
    logic clkS3_q;
    logic enS1_q;
    logic enS2_q;
    logic weS1_q;
    logic weS2_q;
    logic [CAP_ADDR_W-1:0] addrS1_q;
    logic [CAP_ADDR_W-1:0] addrS2_q;
    logic [CAP_DATA_W-1:0] wdS1_q;
    logic [CAP_DATA_W-1:0] wdS2_q;
    // configuration word store
    logic [CAP_DATA_W-1:0] mem [CAP_MEM_DEPTH];
    // access sequencer state
    cap_state_t state_q;
    cap_state_t state_d;
    logic [1:0] lat_q;
    logic [1:0] lat_d;
    logic [CAP_ADDR_W-1:0] addr_q;
    logic [CAP_ADDR_W-1:0] addr_d;
    logic isWrite_q;
    logic isWrite_d;
    // answer registers
    logic [CAP_DATA_W-1:0] rdata_q;
    logic [CAP_DATA_W-1:0] rdata_d;
    logic ready_q;
    logic ready_d;
    // decoded port-clock edges, store write strobe and completion strobe
    logic rise;
    logic fall;
    logic memWe;
    logic setReady;

    // first synchroniser stage on every input from the port-clock side
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clkS1_q <= 1'b0;
            enS1_q <= 1'b0;
            weS1_q <= 1'b0;
            addrS1_q <= '0;
            wdS1_q <= CAP_WORD_RST;
        end else begin
            clkS1_q <= bus.portClk;
            enS1_q <= bus.accessEn;
            weS1_q <= bus.writeSel;
            addrS1_q <= bus.cfgAddr;
            wdS1_q <= bus.cfg_write_data;
        end
    end

    // second stage; only these copies feed any logic
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clkS2_q <= 1'b0;
            enS2_q <= 1'b0;
            weS2_q <= 1'b0;
            addrS2_q <= '0;
            wdS2_q <= CAP_WORD_RST;
        end else begin
            clkS2_q <= clkS1_q;
            enS2_q <= enS1_q;
            weS2_q <= weS1_q;
            addrS2_q <= addrS1_q;
            wdS2_q <= wdS1_q;
        end
    end

    // one more port-clock sample for edge finding; resets low like the idle pin
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            clkS3_q <= 1'b0;
        end else begin
            clkS3_q <= clkS2_q;
        end
    end

    // port-clock edges; inputs sampled at rise, outputs changed at fall
    assign rise = clkS2_q && !clkS3_q;
    assign fall = !clkS2_q && clkS3_q;

    // access sequencer: launch at a rise, wait out the latency, finish at a fall
    always_comb begin
        state_d = state_q;
        addr_d = addr_q;
        isWrite_d = isWrite_q;
        memWe = 1'b0;
        setReady = 1'b0;
        unique case (state_q)
            CAP_IDLE: begin
                if (rise && enS2_q) begin
                    addr_d = addrS2_q;
                    isWrite_d = weS2_q;
                    memWe = weS2_q;
                    state_d = CAP_BUSY;
                end
            end
            CAP_BUSY: begin
                if (rise && lat_q == 2'd0) begin
                    state_d = CAP_DONE;
                end
            end
            CAP_DONE: begin
                if (fall) begin
                    setReady = 1'b1;
                    state_d = CAP_IDLE;
                end
            end
            default: state_d = CAP_IDLE;
        endcase
    end

    // register the sequencer state and the captured request
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            state_q <= CAP_IDLE;
            addr_q <= '0;
            isWrite_q <= 1'b0;
        end else begin
            state_q <= state_d;
            addr_q <= addr_d;
            isWrite_q <= isWrite_d;
        end
    end

    // latency count: loaded at launch, stepped down on each later rise in CAP_BUSY until it reaches zero
    always_comb begin
        lat_d = lat_q;
        if (state_q == CAP_IDLE && rise && enS2_q) begin
            lat_d = 2'(CAP_READ_LAT - 1);
        end else if (state_q == CAP_BUSY && rise && lat_q != 2'd0) begin
            lat_d = lat_q - 2'd1;
        end
    end

    // register the latency count
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            lat_q <= 2'd0;
        end else begin
            lat_q <= lat_d;
        end
    end

    // answer: read word loaded as a read completes and ready raised as any access completes,
    // ready dropped again at the next port-clock fall
    always_comb begin
        rdata_d = rdata_q;
        ready_d = ready_q;
        if (setReady) begin
            if (!isWrite_q) begin
                rdata_d = mem[addr_q];
            end
            ready_d = 1'b1;
        end else if (ready_q && fall) begin
            ready_d = 1'b0;
        end
    end

    // register the answer; the read word holds until the next read
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= CAP_WORD_RST;
            ready_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            ready_q <= ready_d;
        end
    end

    // configuration word store, no reset
    always_ff @(posedge mclk) begin
        if (memWe) begin
            mem[addrS2_q] <= wdS2_q;
        end
    end

    // answer wires toward the requester
    assign bus.cfgReadData = rdata_q;
    assign bus.cfgReady = ready_q;
endmodule // cap_core

// >>> cap_if.sv
// cap_if: wires of the configuration access port between requester and core
// assumes the bench drives mclk and sys_rst to both ends
`timescale 1ns/1ps
interface cap_if;
    import cap_pkg::*;
    logic portClk;                              // port clock, made by the requester
    logic accessEn;                             // access strobe
    logic writeSel;                             // 1 write, 0 read
    logic [CAP_ADDR_W-1:0] cfgAddr;
    logic [CAP_DATA_W-1:0] cfg_write_data;
    logic [CAP_DATA_W-1:0] cfgReadData;
    logic cfgReady;
    modport core (input portClk, accessEn, writeSel, cfgAddr, cfg_write_data,
                  output cfgReadData, cfgReady);
    modport requester (output portClk, accessEn, writeSel, cfgAddr, cfg_write_data,
                       input cfgReadData, cfgReady);
endinterface

// >>> cap_pkg.sv
// cap_pkg: shared constants and types for the configuration access port
// assumes both ends import it whole; no clocking or reset lives here
package cap_pkg;
    localparam int CAP_ADDR_W = 10;          // word address width
    localparam int CAP_DATA_W = 16;          // configuration word width
    localparam int CAP_MEM_DEPTH = 1024;     // words reachable by the address
    localparam int CAP_READ_LAT = 2;         // port-clock rises after launch before done; ready follows at the next fall
    localparam int CAP_CLK_HALF = 8;         // mclk cycles per half port-clock period
    localparam logic [15:0] CAP_WORD_RST = 16'h0000;
    typedef enum logic [1:0] {
        CAP_IDLE = 2'b00,
        CAP_BUSY = 2'b01,
        CAP_DONE = 2'b10
    } cap_state_t;
endpackage

// >>> cap_properties.sv
// cap_properties: timing checks on the configuration access port wires
// assumes mclk samples every wire and sys_rst clears both ends
`timescale 1ns/1ps
module cap_properties
    import cap_pkg::*;
(
    // system
    input wire logic mclk,
    input wire logic sys_rst,
    // port
    input wire logic portClk,
    input wire logic accessEn,
    input wire logic writeSel,
    input wire logic [CAP_ADDR_W-1:0] cfgAddr,
    input wire logic [CAP_DATA_W-1:0] cfg_write_data,
    input wire logic [CAP_DATA_W-1:0] cfgReadData,
    input wire logic cfgReady
);
    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);
    logic pend_q;
    logic pend_d;
    // one access in flight from strobe until ready
    always_comb begin
        pend_d = pend_q;
        if (accessEn) begin
            pend_d = 1'b1;
        end else if (cfgReady) begin
            pend_d = 1'b0;
        end
    end
    // register the in-flight flag
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pend_q <= 1'b0;
        end else begin
            pend_q <= pend_d;
        end
    end
    port_clk_half_a: assert property ($rose(portClk) |-> portClk[*8] ##1 !portClk)
        else $error("port clock high phase wrong");
    strobe_phase_a: assert property ($rose(accessEn) |-> $fell(portClk))
        else $error("strobe not on port clock fall");
    strobe_len_a: assert property ($rose(accessEn) |-> accessEn[*8] ##1 accessEn[*8] ##1 !accessEn)
        else $error("strobe length wrong");
    field_hold_a: assert property (accessEn && $past(accessEn) |->
        $stable(writeSel) && $stable(cfgAddr) && $stable(cfg_write_data))
        else $error("fields moved during strobe");
    single_access_a: assert property ($rose(accessEn) |-> !pend_q)
        else $error("second access while one pending");
    ready_cause_a: assert property ($rose(cfgReady) |-> pend_q)
        else $error("ready without access");
    ready_due_a: assert property ($fell(accessEn) |-> ##[1:60] $rose(cfgReady))
        else $error("ready late or missing");
    ready_len_a: assert property ($rose(cfgReady) |-> cfgReady[*8] ##1 cfgReady[*8] ##1 !cfgReady)
        else $error("ready length wrong");
    rdata_hold_a: assert property (cfgReady && $past(cfgReady) |-> $stable(cfgReadData))
        else $error("read data moved during ready");
    cover property ($rose(accessEn) && writeSel);
    cover property ($rose(accessEn) && !writeSel);
    cover property ($rose(cfgReady));
endmodule // cap_properties

// >>> cap_requester.sv
// cap_requester: fabric end; makes the port clock and runs one access at a time
// assumes the user holds cmd fields stable while cmdValid is high
`timescale 1ns/1ps
module cap_requester
    import cap_pkg::*;
(
    // system
    input wire logic mclk,
    input wire logic sys_rst,
    // user command
    input wire logic cmdValid,
    output logic cmdReady,
    input wire logic cmdWrite,
    input wire logic [CAP_ADDR_W-1:0] cmdAddr,
    input wire logic [CAP_DATA_W-1:0] cmdWdata,
    // user answer
    output logic rspValid,
    output logic [CAP_DATA_W-1:0] rspRdata,
    // port
    cap_if.requester bus
);
    logic [3:0] div_q, div_d;
    logic pclk_q, pclk_d;
    cap_state_t state_q, state_d;
    logic en_q, en_d, we_q, we_d, wasWrite_q, wasWrite_d;
    logic [CAP_ADDR_W-1:0] addr_q, addr_d;
    logic [CAP_DATA_W-1:0] wd_q, wd_d, rd_q, rd_d;
    logic rsp_q, rsp_d;
    logic rdyS1_q, rdyS2_q;
    logic [CAP_DATA_W-1:0] rdS1_q, rdS2_q;
    logic fallTick, riseTick;

    // port clock divider and request sequencer; strobes change on port-clock falls
    assign fallTick = (div_q == 4'(CAP_CLK_HALF - 1)) && pclk_q;
    assign riseTick = (div_q == 4'(CAP_CLK_HALF - 1)) && !pclk_q;
    always_comb begin
        div_d = (div_q == 4'(CAP_CLK_HALF - 1)) ? 4'd0 : div_q + 4'd1;
        pclk_d = (div_q == 4'(CAP_CLK_HALF - 1)) ? !pclk_q : pclk_q;
        state_d = state_q;
        en_d = en_q;
        we_d = we_q;
        wasWrite_d = wasWrite_q;
        addr_d = addr_q;
        wd_d = wd_q;
        rd_d = rd_q;
        rsp_d = 1'b0;
        unique case (state_q)
            CAP_IDLE: begin
                if (cmdValid && fallTick) begin
                    en_d = 1'b1;
                    we_d = cmdWrite;
                    wasWrite_d = cmdWrite;
                    addr_d = cmdAddr;
                    wd_d = cmdWdata;
                    state_d = CAP_BUSY;
                end
            end
            CAP_BUSY: begin
                if (fallTick) begin
                    en_d = 1'b0;
                    we_d = 1'b0;
                    state_d = CAP_DONE;
                end
            end
            CAP_DONE: begin
                if (rdyS2_q && riseTick) begin
                    if (!wasWrite_q) begin
                        rd_d = rdS2_q;
                    end
                    rsp_d = 1'b1;
                    state_d = CAP_IDLE;
                end
            end
            default: state_d = CAP_IDLE;
        endcase
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            div_q <= 4'd0;
            pclk_q <= 1'b0;
            state_q <= CAP_IDLE;
            en_q <= 1'b0;
            we_q <= 1'b0;
            wasWrite_q <= 1'b0;
            addr_q <= '0;
            wd_q <= CAP_WORD_RST;
            rd_q <= CAP_WORD_RST;
            rsp_q <= 1'b0;
            rdyS1_q <= 1'b0;
            rdyS2_q <= 1'b0;
            rdS1_q <= CAP_WORD_RST;
            rdS2_q <= CAP_WORD_RST;
        end else begin
            div_q <= div_d;
            pclk_q <= pclk_d;
            state_q <= state_d;
            en_q <= en_d;
            we_q <= we_d;
            wasWrite_q <= wasWrite_d;
            addr_q <= addr_d;
            wd_q <= wd_d;
            rd_q <= rd_d;
            rsp_q <= rsp_d;
            rdyS1_q <= bus.cfgReady;
            rdyS2_q <= rdyS1_q;
            rdS1_q <= bus.cfgReadData;
            rdS2_q <= rdS1_q;
        end
    end

    // user side and pins
    assign cmdReady = (state_q == CAP_IDLE) && fallTick;
    assign rspValid = rsp_q;
    assign rspRdata = rd_q;
    assign bus.portClk = pclk_q;
    assign bus.accessEn = en_q;
    assign bus.writeSel = we_q;
    assign bus.cfgAddr = addr_q;
    assign bus.cfg_write_data = wd_q;
endmodule // cap_requester

// >>> config_access_port_tb.sv
// config_access_port_tb: drives the requester user side, both ends joined by cap_if
// assumes the requester makes the port clock from mclk
`timescale 1ns/1ps
module config_access_port_tb import cap_pkg::*;;
    logic mclk = 1'b0;
    logic sysRst = 1'b1;
    logic cmdValid = 1'b0;
    logic cmdWrite = 1'b0;
    logic [CAP_ADDR_W-1:0] cmdAddr = '0;
    logic [CAP_DATA_W-1:0] cmdWdata = '0;
    logic cmdReady;
    logic rspValid;
    logic [CAP_DATA_W-1:0] rspRdata;
    logic [15:0] rd;
    int n_fail = 0;
    int comparisons = 0;
    cap_if capBus ();
    cap_core i_cap_core (.mclk(mclk), .sys_rst(sysRst), .bus(capBus.core));
    cap_requester i_cap_requester (.mclk(mclk), .sys_rst(sysRst), .cmdValid(cmdValid),
        .cmdReady(cmdReady), .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdWdata(cmdWdata),
        .rspValid(rspValid), .rspRdata(rspRdata), .bus(capBus.requester));
    cap_properties i_cap_properties (.mclk(mclk), .sys_rst(sysRst), .portClk(capBus.portClk),
        .accessEn(capBus.accessEn), .writeSel(capBus.writeSel), .cfgAddr(capBus.cfgAddr),
        .cfg_write_data(capBus.cfg_write_data), .cfgReadData(capBus.cfgReadData),
        .cfgReady(capBus.cfgReady));
    // 50 ns system clock
    initial forever #25 mclk = ~mclk;
    // word compare
    task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    // flag compare
    task automatic chk1(input string what, input logic exp, input logic got);
        chk16(what, {15'h0000, exp}, {15'h0000, got});
    endtask
    // one access through the user side, strobe, writeSel and cfgAddr checked at launch
    task automatic access(input logic wr, input logic [9:0] a, input logic [15:0] wd);
        int n;
        cmdValid = 1'b1;
        cmdWrite = wr;
        cmdAddr = a;
        cmdWdata = wd;
        n = 0;
        while (cmdReady !== 1'b1 && n < 200) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk1("cmdReady", 1'b1, cmdReady);
        @(posedge mclk);
        #1;
        cmdValid = 1'b0;
        @(posedge mclk);
        #1;
        chk1("accessEn", 1'b1, capBus.accessEn);
        chk1("writeSel", wr, capBus.writeSel);
        chk16("cfgAddr", {6'h00, a}, {6'h00, capBus.cfgAddr});
        n = 0;
        while (rspValid !== 1'b1 && n < 200) begin
            @(posedge mclk);
            #1;
            n++;
        end
        chk1("rspValid", 1'b1, rspValid);
        rd = rspRdata;
        @(posedge mclk);
        #1;
        chk1("rspValid pulse", 1'b0, rspValid);
    endtask
    // boundary and alternating-bit addresses written then read back
    task automatic t_write_read();
        logic [9:0] ad [4] = '{10'h000, 10'h3ff, 10'h155, 10'h2aa};
        for (int i = 0; i < 4; i++) access(1'b1, ad[i], 16'ha5a5 ^ {6'h00, ad[i]});
        for (int i = 0; i < 4; i++) begin
            access(1'b0, ad[i], 16'h0000);
            chk16("read word", 16'ha5a5 ^ {6'h00, ad[i]}, rd);
        end
        $display("test write_read done");
    endtask
    // back-to-back overwrite leaves the neighbour alone
    task automatic t_overwrite();
        access(1'b1, 10'h155, 16'h1234);
        access(1'b1, 10'h155, 16'hfedc);
        access(1'b0, 10'h155, 16'h0000);
        chk16("overwrite", 16'hfedc, rd);
        access(1'b0, 10'h2aa, 16'h0000);
        chk16("neighbour", 16'ha5a5 ^ 16'h02aa, rd);
        $display("test overwrite done");
    endtask
    // no strobe, no ready
    task automatic t_idle();
        int seen;
        seen = 0;
        repeat (40) @(posedge mclk);
        repeat (64) begin
            @(posedge mclk);
            #1;
            if (capBus.cfgReady !== 1'b0 || capBus.accessEn !== 1'b0) seen++;
        end
        chk16("idle activity", 16'h0000, 16'(seen));
        $display("test idle done");
    endtask
    // verdict and end of run
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, n_fail);
        if (n_fail == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        repeat (8) @(posedge mclk);
        #1;
        sysRst = 1'b0;
        t_write_read();
        t_overwrite();
        t_idle();
        stop_test();
    end
    // watchdog
    initial begin
        #200000;
        n_fail++;
        stop_test();
    end
endmodule // config_access_port_tb
